/* rtl/sctl_pkg.sv */
// Purpose: shared constants for the system control fault and watchdog block
// Assumes: 32-bit register bus with byte addresses, one word per register
// Notes:   privilege field layout and timeout encoding are local choices
package sctl_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [5:0] OFF_WDCTL  = 6'h00;
	localparam logic [5:0] OFF_WDSVC  = 6'h04;
	localparam logic [5:0] OFF_ISR    = 6'h08;
	localparam logic [5:0] OFF_FIE    = 6'h0c;
	localparam logic [5:0] OFF_FADDR  = 6'h10;
	localparam logic [5:0] OFF_FLOC   = 6'h14;
	localparam logic [5:0] OFF_FATTR  = 6'h18;
	localparam logic [5:0] OFF_FWDATA = 6'h1c;
	localparam logic [5:0] OFF_MPR    = 6'h20;
	localparam logic [5:0] OFF_PACR0  = 6'h24;
	localparam logic [5:0] OFF_PACR1  = 6'h28;
	localparam logic [5:0] OFF_WDCNT  = 6'h2c;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int WD_EN_BIT   = 0;
	localparam int WD_RSP_LSB  = 1;
	localparam int WD_SEL_LSB  = 4;
	localparam int WD_LOCK_BIT = 15;
	localparam int ISR_WDT_BIT = 0;
	localparam int ISR_FLT_BIT = 1;
	localparam int FIE_EN_BIT  = 0;
	localparam int LOC_BIT     = 7;
	localparam int AT_WR_BIT   = 7;
	localparam int AT_SZ_LSB   = 4;
	localparam int AT_CACHE    = 3;
	localparam int AT_MODE     = 1;
	localparam int AT_TYPE     = 0;
	localparam int PA_SR       = 0;
	localparam int PA_SW       = 1;
	localparam int PA_UR       = 2;
	localparam int PA_UW       = 3;
	// ---------------------------------------------------------------
	// codes and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] RSP_INT    = 2'h0;
	localparam logic [1:0] RSP_RST    = 2'h1;
	localparam logic [1:0] RSP_INTRST = 2'h2;
	localparam logic [1:0] RSP_WIN    = 2'h3;
	localparam logic [7:0] SVC_FIRST  = 8'h55;
	localparam logic [7:0] SVC_SECOND = 8'haa;
	localparam logic [1:0] AV_OKAY    = 2'h0;
	localparam logic [1:0] AV_SLVERR  = 2'h2;
	localparam logic [15:0] WDCTL_RST = 16'h0000;
	localparam logic [3:0]  MPR_RST   = 4'hf;
	localparam logic [31:0] PACR_RST  = 32'h3333_3333;
	typedef enum logic [2:0] {
		WD_OFF = 3'b001,
		WD_RUN = 3'b010,
		WD_EXP = 3'b100
	} sctl_wd_state_e;
endpackage

/* rtl/sctl_fault_watchdog.sv */
// Purpose: bus fault capture, peripheral privilege check and core watchdog
// Assumes: fault and check inputs come from logic on clk_in
// Notes:   registers reached over an Avalon-MM slave with one wait state
//
// How it works
// - location bit 7: 0 internal bus fault, 1 fault inside the core
// - attribute bit 7 holds direction: 0 read, 1 write
// - attribute bits 6-4 hold size: 000 byte, 001 half, 010 word
// - attribute bit 3 set when the faulted access was cacheable
// - attribute bit 1 holds privilege: 0 user, 1 supervisor
// - attribute bit 0 holds type: 0 instruction fetch, 1 data
// - write data register keeps write bus value of the last faulted write
// - every errored processor bus cycle updates the capture registers
// - one master privilege register plus peripheral access registers
// - peripheral accesses lacking rights are aborted, target never reached
// - watchdog is off after reset until software sets enable
// - expiry gives interrupt, reset, or interrupt then reset on second
// - windowed mode: service only in last quarter, earlier write resets
// - any other service value while running resets the system at once
// - count compared to period; control write restarts count from zero
// - write-once lock makes control read-only until system reset
// - interrupt expiry sets status flag, software clears it with 0x01
// - after expiry service writes do not withdraw interrupt or reset
// - fault flag set on every fault, write one clears, zero ignored
// - read-only fault address register holds address of last fault
//
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
module sctl_fault_watchdog #(
	parameter int WDT_MIN_LOG2 = 8
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// register bus
	input  wire logic [5:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic [1:0]       avs_response_out,
	output logic             avs_waitrequest_out,
	// faulted bus cycle report
	input  wire logic        flt_valid_in,
	input  wire logic [31:0] flt_addr_in,
	input  wire logic [31:0] flt_wdata_in,
	input  wire logic        flt_write_in,
	input  wire logic [2:0]  flt_size_in,
	input  wire logic        flt_cache_in,
	input  wire logic        flt_super_in,
	input  wire logic        flt_data_in,
	input  wire logic        flt_core_in,
	// peripheral privilege check
	input  wire logic        pchk_valid_in,
	input  wire logic [1:0]  pchk_master_in,
	input  wire logic [3:0]  pchk_periph_in,
	input  wire logic        pchk_super_in,
	input  wire logic        pchk_write_in,
	output logic             pchk_grant_out,
	output logic             pchk_abort_out,
	// interrupt requests and system reset
	output logic             fault_irq_out,
	output logic             wdt_irq_out,
	output logic             wdt_reset_out
);
	import sctl_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// right check for one peripheral nibble
	function automatic logic priv_ok(input logic [3:0] nib, input logic sup,
		input logic wr);
		if (sup) begin
			return wr ? nib[PA_SW] : nib[PA_SR];
		end
		return wr ? nib[PA_UW] : nib[PA_UR];
	endfunction

	// timeout period in bus clocks from the select field
	function automatic logic [31:0] wd_period_of(input logic [3:0] sel);
		return 32'h1 << (32'(sel) + 32'(WDT_MIN_LOG2));
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [15:0]    wd_ctl;
	logic           fie;
	logic [3:0]     master_privilege_reg;
	logic [31:0]    pacr0;
	logic [31:0]    pacr1;
	logic           fault_flag;
	logic           wdt_flag;
	logic [31:0]    fault_addr;
	logic [7:0]     fault_loc;
	logic [7:0]     fault_attr;
	logic [31:0]    fault_wdata;
	sctl_wd_state_e wd_state;
	logic [31:0]    wd_cnt;
	logic           wd_armed;
	logic [31:0]    next_rdata;
	logic           next_mapped;
	logic [15:0]    next_ctl;
	logic [31:0]    ctl_merged;
	logic [63:0]    pacr_all;
	logic [7:0]     next_attr;
	logic [5:0]     reg_addr;
	logic           acc_wr;
	logic           ctl_wr;
	logic           svc_wr;
	logic           isr_wr;
	logic [7:0]     svc_code;
	logic           wd_locked;
	logic [1:0]     wd_rsp;
	logic [31:0]    wd_period;
	logic           wd_tmo;
	logic           wd_early;
	logic           bad_svc;
	logic           svc_done;
	logic           wdt_irq_ev;
	logic [3:0]     pnib;
	logic           pchk_ok;

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	assign reg_addr  = {avs_address_in[5:2], 2'b00};
	// writes land only at the edge that sees waitrequest low
	assign acc_wr    = avs_write_in && !avs_waitrequest_out;
	assign ctl_wr    = acc_wr && (reg_addr == OFF_WDCTL);
	assign svc_wr    = acc_wr && (reg_addr == OFF_WDSVC) && avs_byteenable_in[0];
	assign isr_wr    = acc_wr && (reg_addr == OFF_ISR) && avs_byteenable_in[0];
	assign svc_code  = avs_writedata_in[7:0];

	// read mux; unmapped words read zero and answer with a slave error
	always_comb begin
		next_rdata  = 32'h0;
		next_mapped = 1'b1;
		case (reg_addr)
			OFF_WDCTL:  next_rdata[15:0] = wd_ctl;
			OFF_WDSVC:  next_rdata = 32'h0;
			OFF_ISR: begin
				next_rdata[ISR_WDT_BIT] = wdt_flag;
				next_rdata[ISR_FLT_BIT] = fault_flag;
			end
			OFF_FIE:    next_rdata[FIE_EN_BIT] = fie;
			OFF_FADDR:  next_rdata = fault_addr;
			OFF_FLOC:   next_rdata[7:0] = fault_loc;
			OFF_FATTR:  next_rdata[7:0] = fault_attr;
			OFF_FWDATA: next_rdata = fault_wdata;
			OFF_MPR:    next_rdata[3:0] = master_privilege_reg;
			OFF_PACR0:  next_rdata = pacr0;
			OFF_PACR1:  next_rdata = pacr1;
			OFF_WDCNT:  next_rdata = wd_cnt;
			default:    next_mapped = 1'b0;
		endcase
	end

	// one wait state: read data is latched as waitrequest falls
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0;
			avs_response_out    <= AV_OKAY;
		end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
			avs_waitrequest_out <= 1'b0;
			avs_readdata_out    <= avs_read_in ? next_rdata : 32'h0;
			avs_response_out    <= next_mapped ? AV_OKAY : AV_SLVERR;
		end else begin
			avs_waitrequest_out <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	assign wd_locked = wd_ctl[WD_LOCK_BIT];
	// a locked control word ignores data, so the lock can never fall
	assign ctl_merged = be_merge({16'h0, wd_ctl}, avs_writedata_in, avs_byteenable_in);
	assign next_ctl   = wd_locked ? wd_ctl : ctl_merged[15:0];

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wd_ctl <= WDCTL_RST;
			fie    <= 1'b0;
			master_privilege_reg    <= MPR_RST;
			pacr0  <= PACR_RST;
			pacr1  <= PACR_RST;
		end else if (acc_wr) begin
			case (reg_addr)
				OFF_WDCTL: wd_ctl <= next_ctl;
				OFF_FIE: begin
					if (avs_byteenable_in[0]) begin
						fie <= avs_writedata_in[FIE_EN_BIT];
					end
				end
				OFF_MPR: begin
					if (avs_byteenable_in[0]) begin
						master_privilege_reg <= avs_writedata_in[3:0];
					end
				end
				OFF_PACR0: pacr0 <= be_merge(pacr0, avs_writedata_in, avs_byteenable_in);
				OFF_PACR1: pacr1 <= be_merge(pacr1, avs_writedata_in, avs_byteenable_in);
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// fault capture
	// ---------------------------------------------------------------
	always_comb begin
		next_attr                         = 8'h00;
		next_attr[AT_WR_BIT]              = flt_write_in;
		next_attr[AT_SZ_LSB +: 3]         = flt_size_in;
		next_attr[AT_CACHE]               = flt_cache_in;
		next_attr[AT_MODE]                = flt_super_in;
		next_attr[AT_TYPE]                = flt_data_in;
	end

	// each errored cycle overwrites the previous capture
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fault_addr  <= 32'h0;
			fault_loc   <= 8'h00;
			fault_attr  <= 8'h00;
			fault_wdata <= 32'h0;
		end else if (flt_valid_in) begin
			fault_addr          <= flt_addr_in;
			fault_loc           <= 8'h00;
			fault_loc[LOC_BIT]  <= flt_core_in;
			fault_attr          <= next_attr;
			if (flt_write_in) begin
				fault_wdata <= flt_wdata_in;
			end
		end
	end

	// ---------------------------------------------------------------
	// status flags and requests
	// ---------------------------------------------------------------
	// a new event in the clearing cycle wins so nothing is lost
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fault_flag <= 1'b0;
			wdt_flag   <= 1'b0;
		end else begin
			if (flt_valid_in) begin
				fault_flag <= 1'b1;
			end else if (isr_wr && avs_writedata_in[ISR_FLT_BIT]) begin
				fault_flag <= 1'b0;
			end
			if (wdt_irq_ev) begin
				wdt_flag <= 1'b1;
			end else if (isr_wr && avs_writedata_in[ISR_WDT_BIT]) begin
				wdt_flag <= 1'b0;
			end
		end
	end

	// enabling the fault request with a stale flag raises it at once
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fault_irq_out <= 1'b0;
			wdt_irq_out   <= 1'b0;
		end else begin
			fault_irq_out <= fault_flag && fie;
			wdt_irq_out   <= wdt_flag;
		end
	end

	// ---------------------------------------------------------------
	// privilege check
	// ---------------------------------------------------------------
	assign pacr_all = {pacr1, pacr0};
	assign pnib     = pacr_all[{pchk_periph_in, 2'b00} +: 4];
	// a master without the privilege bit is always treated as user
	assign pchk_ok = priv_ok(pnib, pchk_super_in && master_privilege_reg[pchk_master_in], pchk_write_in);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pchk_grant_out <= 1'b0;
			pchk_abort_out <= 1'b0;
		end else begin
			pchk_grant_out <= pchk_valid_in && pchk_ok;
			pchk_abort_out <= pchk_valid_in && !pchk_ok;
		end
	end

	// ---------------------------------------------------------------
	// core watchdog
	// ---------------------------------------------------------------
	assign wd_rsp     = wd_ctl[WD_RSP_LSB +: 2];
	assign wd_period  = wd_period_of(wd_ctl[WD_SEL_LSB +: 4]);
	assign wd_tmo     = (wd_cnt == wd_period - 32'h1);
	assign wd_early   = (wd_rsp == RSP_WIN) && (wd_cnt < wd_period - (wd_period >> 2));
	assign bad_svc    = svc_wr && (wd_state == WD_RUN) && (wd_early ||
		((svc_code != SVC_FIRST) && (svc_code != SVC_SECOND)));
	// completing the pair needs wd_armed, set by an earlier SVC_FIRST write
	assign svc_done   = svc_wr && !bad_svc && wd_armed && (svc_code == SVC_SECOND);
	assign wdt_irq_ev = (wd_state == WD_RUN) && wd_tmo && !ctl_wr && !bad_svc &&
		!svc_done && ((wd_rsp == RSP_INT) || (wd_rsp == RSP_INTRST));

	// reset pulse lasts one cycle; system reset then clears everything
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wd_state      <= WD_OFF;
			wd_cnt        <= 32'h0;
			wd_armed      <= 1'b0;
			wdt_reset_out <= 1'b0;
		end else begin
			wdt_reset_out <= 1'b0;
			if (ctl_wr) begin
				wd_cnt   <= 32'h0;
				wd_armed <= 1'b0;
				wd_state <= next_ctl[WD_EN_BIT] ? WD_RUN : WD_OFF;
			end else begin
				case (wd_state)
					WD_OFF: begin
						wd_cnt <= 32'h0;
					end
					WD_RUN: begin
						if (bad_svc) begin
							wdt_reset_out <= 1'b1;
							wd_state      <= WD_OFF;
						end else if (svc_done) begin
							wd_cnt   <= 32'h0;
							wd_armed <= 1'b0;
						end else if (wd_tmo) begin
							wd_cnt   <= 32'h0;
							wd_armed <= 1'b0;
							if ((wd_rsp == RSP_RST) || (wd_rsp == RSP_WIN)) begin
								wdt_reset_out <= 1'b1;
								wd_state      <= WD_OFF;
							end else begin
								wd_state <= WD_EXP;
							end
						end else begin
							wd_cnt <= wd_cnt + 32'h1;
							if (svc_wr && (svc_code == SVC_FIRST)) begin
								wd_armed <= 1'b1;
							end
						end
					end
					WD_EXP: begin
						// service writes are ignored here, so nothing is withdrawn
						if (wd_rsp == RSP_INTRST) begin
							if (wd_tmo) begin
								wdt_reset_out <= 1'b1;
								wd_state      <= WD_OFF;
							end else begin
								wd_cnt <= wd_cnt + 32'h1;
							end
						end
					end
					default: begin
						wd_state <= WD_OFF;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	sequence s_early_write;
		svc_wr && (wd_state == WD_RUN) && (wd_rsp == RSP_WIN) && wd_early;
	endsequence
	sequence s_reset_pulse;
		wdt_reset_out ##1 !wdt_reset_out;
	endsequence

	a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out ##1 avs_waitrequest_out)
		else $error("bus wait state wrong");
	a_loc_capture: assert property (flt_valid_in |=> fault_loc[LOC_BIT] == $past(flt_core_in))
		else $error("fault location not captured");
	a_attr_capture: assert property (flt_valid_in |=> fault_attr == $past(next_attr) && !fault_attr[2])
		else $error("fault attributes not captured");
	a_wdata_capture: assert property (flt_valid_in && flt_write_in |=> fault_wdata == $past(flt_wdata_in))
		else $error("fault write data not captured");
	a_addr_capture: assert property (flt_valid_in |=> fault_addr == $past(flt_addr_in) && fault_flag)
		else $error("fault address or flag missing");
	a_priv_abort: assert property (pchk_valid_in && !pchk_ok |=> pchk_abort_out && !pchk_grant_out)
		else $error("insufficient rights not aborted");
	a_off_at_start: assert property ($rose(wd_state == WD_RUN) |-> $past(ctl_wr) && wd_cnt == 32'h0)
		else $error("watchdog started without control write");
	a_bad_code: assert property (bad_svc && !ctl_wr |=> s_reset_pulse)
		else $error("bad service code did not reset");
	a_window_early: assert property (s_early_write and !ctl_wr |=> wdt_reset_out)
		else $error("early windowed service did not reset");
	a_lock_holds: assert property (wd_locked |=> wd_locked && $stable(wd_ctl))
		else $error("locked control word changed");
	a_expired_stays: assert property (wd_state == WD_EXP && svc_wr && !ctl_wr && !wd_tmo
		|=> wd_state == WD_EXP)
		else $error("service write withdrew expiry");
	a_irq_flag: assert property (wdt_irq_ev |=> wdt_flag ##1 wdt_irq_out)
		else $error("watchdog flag not raised");
endmodule

/* verification/sctl_core_model.sv */
// Purpose: stand-in for the processor core and system bus side
// Assumes: one faulted cycle or one check per call, driven on clk_in
// Notes:   released lines show the inverse of their last value
`timescale 1ns/100ps
module sctl_core_model (
	// clock and check answer
	input  wire logic        clk_in,
	input  wire logic        grant_in,
	input  wire logic        abort_in,
	// fault report: attr is {write, size, cache, super, data, core}
	output logic             flt_valid_out,
	output logic [31:0]      flt_addr_out,
	output logic [31:0]      flt_wdata_out,
	output logic [7:0]       flt_attr_out,
	// check request: req is {master, periph, super, write}
	output logic             pchk_valid_out,
	output logic [7:0]       pchk_req_out
);
	// idle at time zero
	initial begin
		flt_valid_out = 1'b0;
		flt_addr_out = 32'h0;
		flt_wdata_out = 32'h0;
		flt_attr_out = 8'h00;
		pchk_valid_out = 1'b0;
		pchk_req_out = 8'h00;
	end

	// one errored bus cycle; inverted lines catch late sampling
	task automatic fault(input logic [31:0] a, input logic [31:0] d, input logic [7:0] at);
		@(posedge clk_in);
		flt_valid_out <= 1'b1;
		flt_addr_out <= a;
		flt_wdata_out <= d;
		flt_attr_out <= at;
		@(posedge clk_in);
		flt_valid_out <= 1'b0;
		flt_addr_out <= ~a;
		flt_wdata_out <= ~d;
		flt_attr_out <= ~at;
	endtask

	// one peripheral access; answer is sampled one cycle after the pulse
	task automatic check(input logic [7:0] rq, output logic g, output logic a);
		@(posedge clk_in);
		pchk_valid_out <= 1'b1;
		pchk_req_out <= rq;
		@(posedge clk_in);
		pchk_valid_out <= 1'b0;
		pchk_req_out <= ~rq;
		@(posedge clk_in);
		g = grant_in;
		a = abort_in;
	endtask
endmodule

/* verification/sys_control_fault_watchdog_bench.sv */
// Purpose: register-level tests of fault capture, privilege check, watchdog
// Assumes: WDT_MIN_LOG2 = 2, so select s gives a period of 2^(s+2) cycles
// Notes:   reset pulses from the watchdog are counted, not fed back
`timescale 1ns/100ps
module sys_control_fault_watchdog_bench;
	import sctl_pkg::*;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [5:0]  adr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, faddr, fwdata, q, lw;
	logic [1:0]  resp, r;
	logic [7:0]  fattr, preq;
	logic        waitreq, fvalid, pvalid, grant, abort, firq, wirq, wrst;
	int          num_errors = 0;
	int          n_compared = 0;
	int          n_rst = 0;

	sctl_fault_watchdog #(.WDT_MIN_LOG2(2)) sctl_fault_watchdog_i (
		.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_response_out(resp),
		.avs_waitrequest_out(waitreq), .flt_valid_in(fvalid), .flt_addr_in(faddr),
		.flt_wdata_in(fwdata), .flt_write_in(fattr[7]), .flt_size_in(fattr[6:4]),
		.flt_cache_in(fattr[3]), .flt_super_in(fattr[2]), .flt_data_in(fattr[1]),
		.flt_core_in(fattr[0]), .pchk_valid_in(pvalid), .pchk_master_in(preq[7:6]),
		.pchk_periph_in(preq[5:2]), .pchk_super_in(preq[1]), .pchk_write_in(preq[0]),
		.pchk_grant_out(grant), .pchk_abort_out(abort), .fault_irq_out(firq),
		.wdt_irq_out(wirq), .wdt_reset_out(wrst));

	sctl_core_model sctl_core_model_i (
		.clk_in(clk_in), .grant_in(grant), .abort_in(abort), .flt_valid_out(fvalid),
		.flt_addr_out(faddr), .flt_wdata_out(fwdata), .flt_attr_out(fattr),
		.pchk_valid_out(pvalid), .pchk_req_out(preq));

	// ---------------------------------------------------------------
	// clock, reset pulse counter, tasks
	// ---------------------------------------------------------------
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in) if (wrst === 1'b1) n_rst <= n_rst + 1;

	task automatic tally_and_finish();
		if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		adr <= a;
		wdat <= d;
		rd <= ~w;
		wr <= w;
		do begin
			@(posedge clk_in);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) num_errors++;
		q = rdat;
		r = resp;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(nm, q, exp);
	endtask

	// bounded wait: a reset pulse either shows up or must not
	task automatic wait_rst(input int lim, input logic exp, input string nm);
		int b;
		b = n_rst;
		for (int i = 0; i < lim && n_rst == b; i++) @(posedge clk_in);
		chk(nm, n_rst != b, exp);
	endtask

	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim && wirq !== 1'b1; i++) @(posedge clk_in);
		chk("wdt irq", wirq, 1'b1);
	endtask

	task automatic pc(input logic [7:0] rq, input logic [1:0] exp);
		logic g, a;
		sctl_core_model_i.check(rq, g, a);
		chk("grant abort", {g, a}, exp);
	endtask

	function automatic logic [31:0] wd_ctl(input logic [1:0] rsp, input logic [3:0] sel);
		return {24'h0, sel, 1'b0, rsp, 1'b1};
	endfunction

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		int nb;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		rchk("control", OFF_WDCTL, 32'h0);
		rchk("master priv", OFF_MPR, 32'hf);
		rchk("periph acc0", OFF_PACR0, 32'h3333_3333);
		rchk("periph acc1", OFF_PACR1, 32'h3333_3333);
		rchk("status", OFF_ISR, 32'h0);
		bus(1'b0, 6'h30, 32'h0);
		chk("unmapped resp", r, AV_SLVERR);
		wait_rst(300, 1'b0, "idle watchdog");
		chk("idle irq", wirq, 1'b0);
		// each size code once, write data kept only from write faults
		for (int i = 0; i < 3; i++) begin
			logic [7:0] at;
			at = {i != 1, i[2:0], i[0], i != 0, i != 1, i == 1};
			sctl_core_model_i.fault(32'h4000_0010 + i, 32'h5a5a_0000 + i, at);
			if (at[7]) lw = 32'h5a5a_0000 + i;
			rchk("fault addr", OFF_FADDR, 32'h4000_0010 + i);
			rchk("fault loc", OFF_FLOC, {at[0], 7'h0});
			rchk("fault attr", OFF_FATTR, {at[7:3], 1'b0, at[2:1]});
			rchk("fault wdata", OFF_FWDATA, lw);
		end
		rchk("fault flag", OFF_ISR, 32'h2);
		chk("fault irq masked", firq, 1'b0);
		bus(1'b1, OFF_FIE, 32'h1);
		repeat (2) @(posedge clk_in);
		chk("fault irq on", firq, 1'b1);
		bus(1'b1, OFF_ISR, 32'h0);
		rchk("zero write kept", OFF_ISR, 32'h2);
		bus(1'b1, OFF_ISR, 32'h2);
		repeat (2) @(posedge clk_in);
		chk("fault irq off", firq, 1'b0);
		// privilege: reset table gives supervisor read and write only
		pc(8'b00_0000_11, 2'b10);
		pc(8'b00_0000_00, 2'b01);
		pc(8'b00_1001_10, 2'b10);
		bus(1'b1, OFF_PACR0, 32'h3333_3343);
		pc(8'b01_0001_00, 2'b10);
		pc(8'b01_0001_01, 2'b01);
		bus(1'b1, OFF_MPR, 32'he);
		pc(8'b00_0010_10, 2'b01);
		pc(8'b01_0010_10, 2'b10);
		// interrupt response, late service writes change nothing
		bus(1'b1, OFF_WDCTL, wd_ctl(RSP_INT, 4'h0));
		wait_irq(40);
		rchk("wdt flag", OFF_ISR, 32'h1);
		bus(1'b1, OFF_WDSVC, 32'h55);
		bus(1'b1, OFF_WDSVC, 32'h12);
		wait_rst(10, 1'b0, "late service");
		chk("irq kept", wirq, 1'b1);
		bus(1'b1, OFF_ISR, 32'h1);
		repeat (2) @(posedge clk_in);
		chk("irq cleared", wirq, 1'b0);
		bus(1'b1, OFF_WDCTL, wd_ctl(RSP_RST, 4'h0));
		wait_rst(40, 1'b1, "reset expiry");
		bus(1'b1, OFF_WDCTL, wd_ctl(RSP_INTRST, 4'h0));
		wait_irq(40);
		wait_rst(40, 1'b1, "second expiry");
		bus(1'b1, OFF_ISR, 32'h1);
		// 256-cycle period kept alive by service pairs, then by a control write
		bus(1'b1, OFF_WDCTL, wd_ctl(RSP_RST, 4'h6));
		bus(1'b0, OFF_WDCNT, 32'h0);
		chk("count restarted", q < 8, 1'b1);
		nb = n_rst;
		bus(1'b1, OFF_WDSVC, 32'haa);
		for (int k = 0; k < 6; k++) begin
			repeat (60) @(posedge clk_in);
			bus(1'b1, OFF_WDSVC, 32'h55);
			bus(1'b1, OFF_WDSVC, 32'haa);
		end
		chk("serviced", n_rst, nb);
		repeat (200) @(posedge clk_in);
		bus(1'b1, OFF_WDCTL, wd_ctl(RSP_RST, 4'h6));
		wait_rst(200, 1'b0, "control restart");
		wait_rst(100, 1'b1, "unserviced");
		bus(1'b1, OFF_WDCTL, wd_ctl(RSP_INT, 4'h6));
		bus(1'b1, OFF_WDSVC, 32'h12);
		wait_rst(5, 1'b1, "bad code");
		// windowed: early write resets, last quarter accepts the pair
		bus(1'b1, OFF_WDCTL, wd_ctl(RSP_WIN, 4'h6));
		bus(1'b1, OFF_WDSVC, 32'h55);
		wait_rst(5, 1'b1, "early service");
		bus(1'b1, OFF_WDCTL, wd_ctl(RSP_WIN, 4'h6));
		repeat (200) @(posedge clk_in);
		bus(1'b1, OFF_WDSVC, 32'h55);
		bus(1'b1, OFF_WDSVC, 32'haa);
		wait_rst(150, 1'b0, "window service");
		wait_rst(120, 1'b1, "window expiry");
		// lock holds until a system reset
		bus(1'b1, OFF_WDCTL, 32'h8060);
		bus(1'b1, OFF_WDCTL, 32'h0);
		rchk("locked control", OFF_WDCTL, 32'h8060);
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		reset_in <= 1'b0;
		rchk("unlocked", OFF_WDCTL, 32'h0);
		tally_and_finish();
	end

	// hang guard, well beyond the few thousand cycles the tests need
	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end
endmodule
